// File: rtl/dhp_pkg.sv
// package for the acquisition host port: register map, field layout,
// reset values, timing counts and state types shared by both ends.
// assumes nothing beyond a sv-2012 compiler.
package dhp_pkg;

   // bus widths
   localparam int DHP_DW = 16;
   localparam int DHP_AW = 5;   // byte address, bit 0 is byte_lane_select
   localparam int DHP_IW = 4;   // register index width

   // register indices (byte address = index * 2 + lane)
   localparam logic [3:0] REG_CFG = 4'h0;
   localparam logic [3:0] REG_INT_EN = 4'h1;
   localparam logic [3:0] REG_INT_STS = 4'h2;
   localparam logic [3:0] REG_TIMER = 4'h3;
   localparam logic [3:0] REG_FIFO = 4'h4;
   localparam logic [3:0] REG_SEQ_STS = 4'h5;
   localparam logic [3:0] REG_LAST = 4'hD;  // 14 locations, 0..13

   // configuration fields
   localparam int CFG_START_BIT = 0;
   localparam int CFG_RESET_BIT = 1;
   localparam int CFG_STANDBY_BIT = 2;
   localparam int CFG_CAL_BIT = 3;
   localparam int CFG_RP_LSB = 8;   // ram_section_pointer, two bits
   localparam logic [15:0] CFG_RST_VAL = 16'h0000;
   localparam logic [15:0] INT_EN_RST_VAL = 16'h0000;
   localparam logic [15:0] TIMER_RST_VAL = 16'h0000;

   // interrupt status fields
   localparam int STS_CONV_BIT = 0;
   localparam int STS_CAL_BIT = 3;

   // timing: calibration is a fixed count of device clocks, not scaled by SYS_CLK_MHZ
   localparam int SYS_CLK_MHZ = 25;
   localparam int CAL_TIME_US = 989;
   localparam int CAL_REF_MHZ = 5;
   localparam int CAL_CYC = CAL_TIME_US * CAL_REF_MHZ;  // device clocks
   localparam int CONV_CYC = 64;
   localparam int HOST_STROBE_CYC = 6;
   localparam int HOST_RECOVER_CYC = 2;
   localparam logic [3:0] CAL_ALTERED_PTR = 4'h7;

   // host controller registers
   localparam logic [1:0] HREG_CTRL = 2'h0;   // [3:0] index, [8] read
   localparam logic [1:0] HREG_WDATA = 2'h1;
   localparam logic [1:0] HREG_RDATA = 2'h2;
   localparam logic [1:0] HREG_STAT = 2'h3;   // [0] busy, [1] int, [2] wide
   localparam int HCTRL_RD_BIT = 8;

   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_ALE = 2'b01,
      HS_STRB = 2'b11,
      HS_RECV = 2'b10
   } dhp_host_st_e;

   typedef enum logic [1:0] {
      DS_IDLE = 2'b00,
      DS_CAL = 2'b01,
      DS_CONV = 2'b10
   } dhp_dev_st_e;

   // merge a host write into a register, by byte lane in 8-bit mode
   function automatic logic [15:0] dhp_lane_merge(input logic [15:0] old,
         input logic [15:0] wd, input logic wide, input logic lane);
      if (wide) begin
         return wd;
      end else if (lane) begin
         return {wd[7:0], old[7:0]};
      end else begin
         return {old[15:8], wd[7:0]};
      end
   endfunction

   // pick what the data pins show for a register read
   function automatic logic [15:0] dhp_lane_pick(input logic [15:0] val,
         input logic wide, input logic lane);
      if (wide) begin
         return val;
      end else if (lane) begin
         return {8'h00, val[15:8]};
      end else begin
         return {8'h00, val[7:0]};
      end
   endfunction

endpackage

// File: rtl/dhp_bus_if.sv
// parallel host bus between the host controller and the acquisition device.
// assumes one clock for both ends; the shared data wire is resolved here.
`timescale 1ns/1ps
`default_nettype none
interface dhp_bus_if;
   logic cs_n;
   logic rd_n;
   logic wr_n;
   logic ale;
   logic bus_width_select;        // 1 = 16-bit access
   logic [4:0] addr;              // addr[0] is byte_lane_select
   logic [15:0] h_data;
   logic h_data_oe;
   logic [15:0] d_data;
   logic d_data_oe;
   logic [15:0] data;
   logic int_n;

   // resolved data wire, nobody driving reads as zero
   assign data = h_data_oe ? h_data : (d_data_oe ? d_data : 16'h0000);

   modport host (output cs_n, rd_n, wr_n, ale, bus_width_select, addr,
      h_data, h_data_oe, input data, int_n);
   modport dev (input cs_n, rd_n, wr_n, ale, bus_width_select, addr,
      data, output d_data, d_data_oe, int_n);
endinterface
`default_nettype wire

// File: rtl/dhp_sync.sv
// two-flop synchroniser for a bundle of independent level signals.
// assumes each bit may change at any time relative to i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
module dhp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // levels
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   // first stage feeds only the second
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= i_d;
         sync_ff <= meta_ff;
      end
   end

   assign o_q = sync_ff;
endmodule
`default_nettype wire

// File: rtl/dhp_dev.sv
// acquisition device end of the host port: address/cs latch, register set,
// calibration and conversion run control, result fifo and interrupt pin.
// assumes the host holds each strobe low for at least four clocks.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - configuration write with cal code starts calibration
// - calibration lasts fixed count of device clocks
// - calibration end sets status flag, interrupt
// - calibration leaves instruction pointer altered
// - host resets device after calibration
// - start bit one starts conversions, fields together
// - start bit zero stops conversions
// - status register names the interrupt cause
// - internal clock halts while chip selected
// - host avoids reads during timed conversions; tb_top reads REG_CFG and REG_INT_STS while converting
// - host drains fifo before it overflows
// - address latch strobe with internal latches
// - width pin selects 8 or 16 bits
// - 8-bit mode: lane bit picks byte
// - 16-bit mode ignores lane bit
// - fourteen word or 28 byte locations
// - chip select latched with address
// - host decodes address into chip select; dhp_host asserts cs_n on every access from its state alone
// - active-low request drives host interrupt
// - host leaves aliased window otherwise empty
// - fifo pointers independent, wrap after 32
// - all fifo entries through one address
// - status bit sets even when masked
module dhp_dev
   import dhp_pkg::*;
#(
   parameter int FIFO_DEPTH = 32,
   parameter int CAL_CYCLES = CAL_CYC,
   parameter int CONV_CYCLES = CONV_CYC
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // host bus
   dhp_bus_if.dev bus,
   // converter side
   input wire logic [15:0] i_sample,
   output logic o_converting,
   output logic o_calibrating,
   output logic o_clk_halted
);
   localparam int PW = $clog2(FIFO_DEPTH);

   logic [4:0] addr_lat_ff;
   logic cs_lat_ff;
   logic [2:0] strb_s;
   logic cs_s;
   logic rd_s;
   logic wr_s;
   logic rd_prev_ff;
   logic wr_prev_ff;
   logic [15:0] wdata_ff;
   logic [15:0] rdata_ff;
   logic [15:0] cfg_ff;
   logic [15:0] int_en_ff;
   logic [15:0] timer_ff;
   logic [15:0] sts_ff;
   logic [15:0] fifo_mem [FIFO_DEPTH];
   logic [PW-1:0] wr_ptr_ff;
   logic [PW-1:0] rd_ptr_ff;
   logic [3:0] ins_ptr_ff;
   logic [12:0] cal_cnt_ff;
   logic [15:0] conv_cnt_ff;
   dhp_dev_st_e st_ff;
   logic run;
   logic wide;
   logic lane;
   logic [3:0] idx;
   logic rd_fall;
   logic rd_rise;
   logic wr_rise;
   logic wr_cfg;
   logic cal_done;
   logic conv_done;
   logic soft_rst;
   logic last_byte;
   logic [15:0] reg_val;

   // address and chip select follow the pins while ale is high
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         addr_lat_ff <= 5'h00;
         cs_lat_ff <= 1'b1;
      end else if (bus.ale) begin
         addr_lat_ff <= bus.addr;
         cs_lat_ff <= bus.cs_n;
      end
   end

   // strobes and latched select into the device clock domain
   dhp_sync #(.W(3), .RST_VAL(3'b111)) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_d({cs_lat_ff, bus.rd_n, bus.wr_n}),
      .o_q(strb_s)
   );
   assign cs_s = strb_s[2];
   assign rd_s = strb_s[1] | cs_s;
   assign wr_s = strb_s[0] | cs_s;

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         rd_prev_ff <= 1'b1;
         wr_prev_ff <= 1'b1;
      end else begin
         rd_prev_ff <= rd_s;
         wr_prev_ff <= wr_s;
      end
   end

   // decode
   assign wide = bus.bus_width_select;
   assign lane = wide ? 1'b0 : addr_lat_ff[0];
   assign idx = addr_lat_ff[4:1];
   assign last_byte = wide | lane;
   assign rd_fall = rd_prev_ff & ~rd_s;
   assign rd_rise = ~rd_prev_ff & rd_s;
   assign wr_rise = ~wr_prev_ff & wr_s;
   assign wr_cfg = wr_rise && idx == REG_CFG;
   assign run = cs_s;
   // config actions fire on the low byte or a whole word, never on the high byte
   assign soft_rst = wr_cfg && (wide || !lane) && wdata_ff[CFG_RESET_BIT];

   // write data taken from the pins while the selected write strobe is low;
   // the synchronised strobe outlasts the host's drive, so it cannot gate this
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         wdata_ff <= 16'h0000;
      end else if (!bus.wr_n && !cs_lat_ff) begin
         wdata_ff <= bus.data;
      end
   end

   // writable registers; reset and cal bits act once and read back zero
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         cfg_ff <= CFG_RST_VAL;
         int_en_ff <= INT_EN_RST_VAL;
         timer_ff <= TIMER_RST_VAL;
      end else if (wr_rise) begin
         case (idx)
            REG_CFG: begin
               cfg_ff <= dhp_lane_merge(cfg_ff, wdata_ff, wide, lane);
               cfg_ff[CFG_RESET_BIT] <= 1'b0;
               cfg_ff[CFG_CAL_BIT] <= 1'b0;
            end
            REG_INT_EN: int_en_ff <= dhp_lane_merge(int_en_ff, wdata_ff, wide, lane);
            REG_TIMER: timer_ff <= dhp_lane_merge(timer_ff, wdata_ff, wide, lane);
            default: ;
         endcase
      end
   end

   // run control: calibration and conversion sequencer
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         st_ff <= DS_IDLE;
         cal_cnt_ff <= 13'h0000;
         conv_cnt_ff <= 16'h0000;
      end else if (soft_rst) begin
         st_ff <= DS_IDLE;
         cal_cnt_ff <= 13'h0000;
         conv_cnt_ff <= 16'h0000;
      end else if (wr_cfg && wdata_ff[CFG_CAL_BIT] && (wide || !lane)) begin
         st_ff <= DS_CAL;
         cal_cnt_ff <= 13'h0000;
      end else if (wr_cfg && (wide || !lane)) begin
         // start and the other fields land in the same write
         st_ff <= wdata_ff[CFG_START_BIT] ? DS_CONV : DS_IDLE;
         conv_cnt_ff <= 16'h0000;
      end else if (run) begin
         case (st_ff)
            DS_CAL: begin
               if (cal_done) begin
                  st_ff <= DS_IDLE;
               end else begin
                  cal_cnt_ff <= cal_cnt_ff + 13'h0001;
               end
            end
            DS_CONV: begin
               conv_cnt_ff <= conv_done ? 16'h0000 : conv_cnt_ff + 16'h0001;
            end
            DS_IDLE: ;
            default: st_ff <= DS_IDLE;
         endcase
      end
   end
   assign cal_done = st_ff == DS_CAL && run && cal_cnt_ff == 13'(CAL_CYCLES - 1);
   assign conv_done = st_ff == DS_CONV && run && conv_cnt_ff == 16'(CONV_CYCLES - 1);

   // instruction pointer steps per conversion; calibration disturbs it
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || soft_rst) begin
         ins_ptr_ff <= 4'h0;
      end else if (cal_done) begin
         ins_ptr_ff <= CAL_ALTERED_PTR;
      end else if (conv_done) begin
         ins_ptr_ff <= ins_ptr_ff + 4'h1;
      end
   end

   // result fifo: writes and reads keep separate wrapping pointers
   always_ff @(posedge i_sys_clk) begin
      if (conv_done) begin
         fifo_mem[wr_ptr_ff] <= i_sample;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || soft_rst) begin
         wr_ptr_ff <= '0;
      end else if (conv_done) begin
         wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || soft_rst) begin
         rd_ptr_ff <= '0;
      end else if (rd_rise && idx == REG_FIFO && last_byte) begin
         rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
   end

   // sticky status; an event in the clearing cycle still sets its bit
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || soft_rst) begin
         sts_ff <= 16'h0000;
      end else begin
         if (rd_rise && idx == REG_INT_STS && last_byte) begin
            sts_ff <= 16'h0000;
         end
         if (cal_done) begin
            sts_ff[STS_CAL_BIT] <= 1'b1;
         end
         if (conv_done) begin
            sts_ff[STS_CONV_BIT] <= 1'b1;
         end
      end
   end

   // read mux
   always_comb begin
      case (idx)
         REG_CFG: reg_val = cfg_ff;
         REG_INT_EN: reg_val = int_en_ff;
         REG_INT_STS: reg_val = sts_ff;
         REG_TIMER: reg_val = timer_ff;
         REG_FIFO: reg_val = fifo_mem[rd_ptr_ff];
         REG_SEQ_STS: reg_val = {10'h000, st_ff, ins_ptr_ff};
         default: reg_val = 16'h0000;
      endcase
   end

   // read data is loaded once the strobe falls in the device domain
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         rdata_ff <= 16'h0000;
      end else if (rd_fall) begin
         rdata_ff <= dhp_lane_pick(reg_val, wide, lane);
      end
   end

   // pins
   assign bus.d_data = rdata_ff;
   assign bus.d_data_oe = ~cs_lat_ff & ~bus.rd_n;
   assign bus.int_n = ~|(sts_ff & int_en_ff);
   assign o_converting = st_ff == DS_CONV;
   assign o_calibrating = st_ff == DS_CAL;
   assign o_clk_halted = ~run;
endmodule
`default_nettype wire

// File: rtl/dhp_host.sv
// host end of the acquisition port: runs register accesses on the
// parallel bus, splitting words into two byte cycles in 8-bit mode.
// assumes software waits for busy to drop before the next access.
`timescale 1ns/1ps
`default_nettype none
module dhp_host
   import dhp_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // software port
   input wire logic [1:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   // configuration
   input wire logic i_wide,
   output logic o_irq,
   // device bus
   dhp_bus_if.host bus
);
   dhp_host_st_e st_ff;
   logic [3:0] idx_ff;
   logic dir_rd_ff;
   logic lane_ff;
   logic [15:0] wbuf_ff;
   logic [15:0] rbuf_ff;
   logic [3:0] cnt_ff;
   logic [15:0] rdata_ff;
   logic wide_ff;
   logic busy;
   logic go;

   assign busy = st_ff != HS_IDLE;
   assign go = i_wr && i_addr == HREG_CTRL && !busy;

   // width strap caught when idle
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         wide_ff <= 1'b1;
      end else if (!busy) begin
         wide_ff <= i_wide;
      end
   end

   // write buffer and command
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         wbuf_ff <= 16'h0000;
         idx_ff <= 4'h0;
         dir_rd_ff <= 1'b0;
      end else if (i_wr && i_addr == HREG_WDATA && !busy) begin
         wbuf_ff <= i_wdata;
      end else if (go) begin
         idx_ff <= i_wdata[3:0];
         dir_rd_ff <= i_wdata[HCTRL_RD_BIT];
      end
   end

   // access sequencer: ale, strobe, recovery, once or twice per word
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         st_ff <= HS_IDLE;
         cnt_ff <= 4'h0;
         lane_ff <= 1'b0;
         rbuf_ff <= 16'h0000;
      end else begin
         case (st_ff)
            HS_IDLE: begin
               lane_ff <= 1'b0;
               if (go) begin
                  st_ff <= HS_ALE;
               end
            end
            HS_ALE: begin
               st_ff <= HS_STRB;
               cnt_ff <= 4'h0;
            end
            HS_STRB: begin
               if (cnt_ff == 4'(HOST_STROBE_CYC - 1)) begin
                  // capture the pins at the last strobe cycle
                  if (wide_ff) begin
                     rbuf_ff <= bus.data;
                  end else if (lane_ff) begin
                     rbuf_ff[15:8] <= bus.data[7:0];
                  end else begin
                     rbuf_ff[7:0] <= bus.data[7:0];
                  end
                  st_ff <= HS_RECV;
                  cnt_ff <= 4'h0;
               end else begin
                  cnt_ff <= cnt_ff + 4'h1;
               end
            end
            HS_RECV: begin
               if (cnt_ff == 4'(HOST_RECOVER_CYC - 1)) begin
                  lane_ff <= 1'b1;
                  st_ff <= (wide_ff || lane_ff) ? HS_IDLE : HS_ALE;
               end else begin
                  cnt_ff <= cnt_ff + 4'h1;
               end
            end
            default: st_ff <= HS_IDLE;
         endcase
      end
   end

   // bus pins; select follows the ale and strobe states, not the register index
   assign bus.ale = st_ff == HS_IDLE || st_ff == HS_ALE;
   assign bus.cs_n = !(st_ff == HS_ALE || st_ff == HS_STRB);
   assign bus.addr = {idx_ff, lane_ff & ~wide_ff};
   assign bus.rd_n = !(st_ff == HS_STRB && dir_rd_ff);
   assign bus.wr_n = !(st_ff == HS_STRB && !dir_rd_ff);
   assign bus.h_data = (wide_ff || !lane_ff) ? wbuf_ff : {8'h00, wbuf_ff[15:8]};
   assign bus.h_data_oe = st_ff == HS_STRB && !dir_rd_ff;
   assign bus.bus_width_select = wide_ff;
   assign o_irq = ~bus.int_n;

   // software read port, data one cycle after the strobe
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         rdata_ff <= 16'h0000;
      end else if (i_rd) begin
         case (i_addr)
            HREG_CTRL: rdata_ff <= {7'h00, dir_rd_ff, 4'h0, idx_ff};
            HREG_WDATA: rdata_ff <= wbuf_ff;
            HREG_RDATA: rdata_ff <= rbuf_ff;
            HREG_STAT: rdata_ff <= {13'h0000, wide_ff, ~bus.int_n, busy};
            default: rdata_ff <= 16'h0000;
         endcase
      end
   end
   assign o_rdata = rdata_ff;
endmodule
`default_nettype wire

// File: dv/dhp_properties.sv
// checker for the host bus joining the two ends of the acquisition port.
// assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dhp_properties (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // bus signals
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic ale,
   input wire logic bus_width_select,
   input wire logic [4:0] addr,
   input wire logic h_data_oe,
   input wire logic d_data_oe,
   input wire logic int_n
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);
   // device drives data only inside a read strobe
   property p_oe_in_read;
      d_data_oe |-> (!rd_n && wr_n);
   endproperty
   a_oe_in_read: assert property (p_oe_in_read) else $error("device drives outside read");
   // a selected read strobe after the latch gets the device on the wire
   property p_oe_on_read;
      (!cs_n && !ale && !rd_n) |-> d_data_oe;
   endproperty
   a_oe_on_read: assert property (p_oe_on_read) else $error("selected read not driven");
   // never both ends on the data wire
   property p_no_fight;
      !(h_data_oe && d_data_oe);
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
   // one strobe at a time, each under chip select
   property p_cs_strobe;
      (!rd_n || !wr_n) |-> (!cs_n && (rd_n || wr_n));
   endproperty
   a_cs_strobe: assert property (p_cs_strobe) else $error("strobe overlap or unselected");
   // strobe long enough for the synchroniser
   property p_strobe_len;
      ($fell(rd_n) || $fell(wr_n)) |-> (!rd_n || !wr_n)[*4];
   endproperty
   a_strobe_len: assert property (p_strobe_len) else $error("strobe too short");
   // gap between strobes
   property p_strobe_gap;
      ($rose(rd_n) || $rose(wr_n)) |-> (rd_n && wr_n)[*3];
   endproperty
   a_strobe_gap: assert property (p_strobe_gap) else $error("strobe gap too short");
   // address and select are latched just before each strobe
   property p_ale_first;
      ($fell(rd_n) || $fell(wr_n)) |-> ($past(ale) && !$past(cs_n) && !ale);
   endproperty
   a_ale_first: assert property (p_ale_first) else $error("strobe without latch cycle");
   // 8-bit mode: low byte write cycle is followed by the high byte write cycle
   property p_byte_pair;
      ($fell(wr_n) && !bus_width_select && !addr[0]) |-> ##[7:12] ($fell(wr_n) && addr[0]);
   endproperty
   a_byte_pair: assert property (p_byte_pair) else $error("upper byte cycle missing");
   // main scenarios seen
   c_irq: cover property ($fell(int_n));
   c_rd8: cover property ($fell(rd_n) && !bus_width_select);
   c_wr16: cover property ($fell(wr_n) && bus_width_select);
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// testbench joining host and device ends, driven through the host software port.
// assumes the host splits words into byte cycles and reassembles read words.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import dhp_pkg::*;
;
   localparam int CALN = 20;
   logic i_sys_clk, i_rst_n, i_wr, i_rd, i_wide, o_irq;
   logic o_converting, o_calibrating, o_clk_halted;
   logic [1:0] i_addr;
   logic [15:0] i_wdata, o_rdata, i_sample, rv;
   int n_fail, num_checks, n;
   int n_halt = 0;
   dhp_bus_if dhp_bus_if_inst ();
   dhp_host dhp_host_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_wide(i_wide),
      .o_irq(o_irq), .bus(dhp_bus_if_inst.host));
   dhp_dev #(.CAL_CYCLES(CALN), .CONV_CYCLES(8)) dhp_dev_inst (.i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n), .bus(dhp_bus_if_inst.dev), .i_sample(i_sample),
      .o_converting(o_converting), .o_calibrating(o_calibrating), .o_clk_halted(o_clk_halted));
   dhp_properties dhp_properties_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .cs_n(dhp_bus_if_inst.cs_n), .rd_n(dhp_bus_if_inst.rd_n), .wr_n(dhp_bus_if_inst.wr_n),
      .ale(dhp_bus_if_inst.ale), .bus_width_select(dhp_bus_if_inst.bus_width_select),
      .addr(dhp_bus_if_inst.addr), .h_data_oe(dhp_bus_if_inst.h_data_oe),
      .d_data_oe(dhp_bus_if_inst.d_data_oe), .int_n(dhp_bus_if_inst.int_n));
   // clock
   initial begin
      i_sys_clk = 1'b0;
      forever #20 i_sys_clk = ~i_sys_clk;
   end
   // count cycles with the device clock paused
   always @(posedge i_sys_clk) begin
      if (o_clk_halted === 1'b1) begin
         n_halt++;
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (n_fail == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic sw_wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask
   task automatic sw_rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      @(negedge i_sys_clk);
      d = o_rdata;
   endtask
   // one device register access through the host controller
   task automatic acc(input logic [3:0] idx, input logic [15:0] wd, input logic rd,
         output logic [15:0] d);
      logic [15:0] s;
      int k;
      sw_wr(HREG_WDATA, wd);
      sw_wr(HREG_CTRL, {7'h00, rd, 4'h0, idx});
      k = 0;
      s = 16'hffff;
      while (s[0] !== 1'b0) begin
         sw_rd(HREG_STAT, s);
         k++;
         if (k > 40) begin
            n_fail++;
            conclude();
         end
      end
      sw_rd(HREG_RDATA, d);
   endtask
   task automatic set_wide(input logic w);
      @(posedge i_sys_clk);
      i_wide <= w;
   endtask
   // wait for calibrating (sel 0) or converting (sel 1) to reach v, counting cycles
   task automatic wait_sig(input int sel, input logic v, output int c);
      c = 0;
      while (((sel == 0) ? o_calibrating : o_converting) !== v) begin
         @(posedge i_sys_clk);
         #1;
         c++;
         if (c > 400) begin
            n_fail++;
            conclude();
         end
      end
   endtask
   // main sequence
   initial begin
      i_rst_n = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 2'h0;
      i_wdata = 16'h0000;
      i_wide = 1'b1;
      i_sample = 16'h0abc;
      n_fail = 0;
      num_checks = 0;
      repeat (2) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      acc(REG_CFG, 16'h0000, 1'b1, rv);
      check(rv, CFG_RST_VAL);
      // word and byte widths, unmapped location
      for (int w = 0; w < 2; w++) begin
         set_wide(w[0]);
         acc(REG_TIMER, 16'h5a3c ^ {16{w[0]}}, 1'b0, rv);
         acc(REG_TIMER, 16'h0000, 1'b1, rv);
         check(rv, 16'h5a3c ^ {16{w[0]}});
         set_wide(~w[0]);
         acc(REG_TIMER, 16'h0000, 1'b1, rv);
         check(rv, 16'h5a3c ^ {16{w[0]}});
         acc(4'hd, 16'hffff, 1'b0, rv);
         acc(4'hd, 16'h0000, 1'b1, rv);
         check(rv, 16'h0000);
      end
      check({15'h0000, n_halt > 0}, 16'h0001);
      // calibration
      set_wide(1'b1);
      acc(REG_INT_EN, 16'h0008, 1'b0, rv);
      acc(REG_CFG, 16'h0008, 1'b0, rv);
      wait_sig(0, 1'b1, n);
      check({15'h0000, o_calibrating}, 16'h0001);
      wait_sig(0, 1'b0, n);
      check({15'h0000, n >= CALN - 1 && n <= CALN + 2}, 16'h0001);
      check({15'h0000, o_irq}, 16'h0001);
      acc(REG_INT_STS, 16'h0000, 1'b1, rv);
      check(rv & 16'h0008, 16'h0008);
      acc(REG_INT_STS, 16'h0000, 1'b1, rv);
      check(rv, 16'h0000);
      acc(REG_SEQ_STS, 16'h0000, 1'b1, rv);
      check({12'h000, rv[3:0]}, {12'h000, CAL_ALTERED_PTR});
      acc(REG_CFG, 16'h0002, 1'b0, rv);
      acc(REG_SEQ_STS, 16'h0000, 1'b1, rv);
      check({12'h000, rv[3:0]}, 16'h0000);
      // conversions with the result interrupt masked
      acc(REG_INT_EN, 16'h0000, 1'b0, rv);
      acc(REG_CFG, 16'h0201, 1'b0, rv);
      wait_sig(1, 1'b1, n);
      acc(REG_CFG, 16'h0000, 1'b1, rv);
      check(rv & 16'h0301, 16'h0201);
      repeat (40) @(posedge i_sys_clk);
      acc(REG_INT_STS, 16'h0000, 1'b1, rv);
      check(rv & 16'h0001, 16'h0001);
      check({15'h0000, o_irq}, 16'h0000);
      acc(REG_CFG, 16'h0200, 1'b0, rv);
      wait_sig(1, 1'b0, n);
      check({15'h0000, o_converting}, 16'h0000);
      acc(REG_FIFO, 16'h0000, 1'b1, rv);
      check(rv, 16'h0abc);
      acc(REG_FIFO, 16'h0000, 1'b1, rv);
      check(rv, 16'h0abc);
      conclude();
   end
endmodule
`default_nettype wire
